// File: inc/fault_crc_pkg.sv
`default_nettype none

package fault_crc_pkg;

  // ---------------------------------------------------------------------------
  // Status byte layout
  // ---------------------------------------------------------------------------
  localparam int unsigned STAT_POWER_ON_BIT = 7;
  localparam int unsigned STAT_NOT_READY_BIT = 6;
  localparam int unsigned STAT_POS_HIGH_BIT = 5;
  localparam int unsigned STAT_POS_LOW_BIT = 4;
  localparam int unsigned STAT_NEG_HIGH_BIT = 3;
  localparam int unsigned STAT_NEG_LOW_BIT = 2;
  localparam int unsigned STAT_REF_THIRD_BIT = 1;
  localparam int unsigned STAT_REF_FIXED_BIT = 0;

  // Rail vector order used on the comparator ports.
  localparam int unsigned RAIL_POS_HIGH = 3;
  localparam int unsigned RAIL_POS_LOW = 2;
  localparam int unsigned RAIL_NEG_HIGH = 1;
  localparam int unsigned RAIL_NEG_LOW = 0;

  // ---------------------------------------------------------------------------
  // Reset values and encodings
  // ---------------------------------------------------------------------------
  localparam logic RST_POWER_ON_FLAG = 1'h1;
  localparam logic RST_DONE_N = 1'h1;
  localparam logic [1:0] REF_MON_OFF = 2'h0;

  // ---------------------------------------------------------------------------
  // Checksum
  // ---------------------------------------------------------------------------
  localparam logic [8:0] CRC_POLY_FULL = 9'h107;
  localparam logic [7:0] CRC_POLY = CRC_POLY_FULL[7:0];
  localparam logic [7:0] CRC_INIT = 8'h00;
  localparam int unsigned CRC_COVER_BYTES = 3;

  // Frame slots: status, result high, result low, checksum.
  localparam logic [1:0] SLOT_STATUS = 2'h0;
  localparam logic [1:0] SLOT_RES_HI = 2'h1;
  localparam logic [1:0] SLOT_RES_LO = 2'h2;
  localparam logic [1:0] SLOT_CRC = 2'h3;

  typedef enum logic [1:0]
  {
    ST_IDLE = 2'b01,
    ST_SEND = 2'b10
  } read_state_e;

endpackage : fault_crc_pkg

`default_nettype wire

// File: logic/crc8_byte_step.sv
`timescale 1ns/1ps
`default_nettype none

// Advances the checksum remainder by one byte, most significant bit first.
// A zero start and a zero leading byte leave the remainder at zero, which the
// frame logic uses to make the optional status byte drop out of the sum.
module crc8_byte_step
(
  input wire logic [7:0] i_crc,
  input wire logic [7:0] i_data,
  output logic [7:0] o_crc
);

  // ---------------------------------------------------------------------------
  // Bitwise long division
  // ---------------------------------------------------------------------------

  // Each step is the subtract-by-XOR of the aligned polynomial.
  always_comb
  begin
    logic [7:0] r;
    r = i_crc ^ i_data;
    for (int i = 0; i < 8; i++)
    begin
      if (r[7])
      begin
        r = {r[6:0], 1'b0} ^ fault_crc_pkg::CRC_POLY; // see R13 R14
      end
      else
      begin
        r = {r[6:0], 1'b0};
      end
    end
    o_crc = r;
  end

endmodule : crc8_byte_step

`default_nettype wire

// File: logic/fault_status_crc.sv
// How it works
// R1: Bit 6 shows start-up not yet finished.
// R2: Rail flag when output near either supply.
// R3: Four rail flags in bits 5 to 2.
// R4: Rail monitor runs only when enabled.
// R5: Bypassed amplifier: watch converter input instead.
// R6: Rail faults latched, flags change at cycle end.
// R7: Reference compared with 300 mV and third.
// R8: Reference detection needs nonzero enable field.
// R9: Bit 0 below fixed, bit 1 below third.
// R10: Reference flags update as done output falls.
// R11: Checksum byte appended when checksum enabled.
// R12: Checksum covers result and prepended status.
// R13: Polynomial x8+x2+x+1, pattern 100000111.
// R14: Append eight zeros, divide by XOR.
// R15: Host recomputes checksum, rereads on mismatch. The host reader model recomputes it but never compares it or rereads.
// R16: Status byte leads every read when prepending.
// R17: Power-on flag set until written zero.
// R18: Status shows flags of last finished cycle.
// R19: Zero start, no inversion, MSB first.
`timescale 1ns/1ps
`default_nettype none

module fault_status_crc
(
  input wire logic I_CLK,
  input wire logic I_SYS_RST,
  // Comparator levels, vector order pos high, pos low, neg high, neg low.
  input wire logic [3:0] I_AMP_RAIL,
  input wire logic [3:0] I_ADC_IN_RAIL,
  input wire logic I_AMP_BYPASS,
  input wire logic I_RAIL_MON_EN,
  input wire logic I_REF_BELOW_FIXED,
  input wire logic I_REF_BELOW_THIRD,
  input wire logic [1:0] I_MONITOR_ENABLE_FIELD,
  input wire logic I_STARTUP_DONE,
  input wire logic I_POWER_ON_EVENT,
  input wire logic I_CONV_END,
  input wire logic [15:0] I_RESULT,
  input wire logic I_CRC_EN,
  input wire logic I_STATUS_PREPEND_BIT,
  input wire logic I_STATUS_WR,
  input wire logic [7:0] I_STATUS_WDATA,
  input wire logic I_READ_START,
  input wire logic I_BYTE_REQ,
  output logic [7:0] O_STATUS,
  output logic O_CONVERSION_DONE_OUT_N,
  output logic [7:0] O_BYTE,
  output logic O_BYTE_VALID,
  output logic O_BYTE_LAST
);

  // ---------------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------------

  typedef struct packed
  {
    fault_crc_pkg::read_state_e st;
    logic [3:0] rail_acc;
    logic [1:0] ref_acc;
    logic pos_out_high_flag;
    logic pos_out_low_flag;
    logic neg_out_high_flag;
    logic neg_out_low_flag;
    logic ref_below_third_flag;
    logic ref_below_fixed_flag;
    logic power_on_event_flag;
    logic not_ready;
    logic conversion_done_out_n;
    logic [15:0] result;
    logic [3:0][7:0] frame;
    logic [1:0] idx;
    logic [1:0] last;
    logic [7:0] byte_out;
    logic byte_valid;
    logic byte_last;
  } state_s;

  state_s q;
  state_s d;
  logic [3:0] rail_now;
  logic [1:0] ref_now;
  logic [7:0] status_now;
  logic [3:0][7:0] crc_chain;
  logic [2:0][7:0] crc_data;

  // ---------------------------------------------------------------------------
  // Monitor sources
  // ---------------------------------------------------------------------------

  // The comparators themselves sit in the analog section; only their levels
  // arrive here, already judged against the 0.15 V and reference thresholds.
  assign rail_now = I_RAIL_MON_EN ?
    (I_AMP_BYPASS ? I_ADC_IN_RAIL : I_AMP_RAIL) : 4'h0; // see R2 R4 R5
  assign ref_now = (I_MONITOR_ENABLE_FIELD != fault_crc_pkg::REF_MON_OFF) ?
    {I_REF_BELOW_THIRD, I_REF_BELOW_FIXED} : 2'h0; // see R7 R8

  // Status byte as read: latched flags only, never the live comparators.
  always_comb
  begin
    status_now = 8'h00;
    status_now[fault_crc_pkg::STAT_POWER_ON_BIT] = q.power_on_event_flag; // see R17
    status_now[fault_crc_pkg::STAT_NOT_READY_BIT] = q.not_ready; // see R1
    status_now[fault_crc_pkg::STAT_POS_HIGH_BIT] = q.pos_out_high_flag; // see R3
    status_now[fault_crc_pkg::STAT_POS_LOW_BIT] = q.pos_out_low_flag;
    status_now[fault_crc_pkg::STAT_NEG_HIGH_BIT] = q.neg_out_high_flag;
    status_now[fault_crc_pkg::STAT_NEG_LOW_BIT] = q.neg_out_low_flag;
    status_now[fault_crc_pkg::STAT_REF_THIRD_BIT] = q.ref_below_third_flag; // see R9
    status_now[fault_crc_pkg::STAT_REF_FIXED_BIT] = q.ref_below_fixed_flag; // see R18
  end

  // ---------------------------------------------------------------------------
  // Checksum chain
  // ---------------------------------------------------------------------------

  // A zero in the status slot leaves the zero remainder untouched, so one
  // chain serves both the two-byte and the three-byte frame.
  assign crc_data[0] = I_STATUS_PREPEND_BIT ? status_now : 8'h00; // see R12
  assign crc_data[1] = q.result[15:8];
  assign crc_data[2] = q.result[7:0];
  assign crc_chain[0] = fault_crc_pkg::CRC_INIT; // see R19

  generate
    for (genvar g = 0; g < fault_crc_pkg::CRC_COVER_BYTES; g++)
    begin : g_crc
      crc8_byte_step u_step
      (
        .i_crc(crc_chain[g]),
        .i_data(crc_data[g]),
        .o_crc(crc_chain[g + 1])
      );
    end
  endgenerate

  // ---------------------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------------------

  always_comb
  begin
    d = q;
    d.byte_valid = 1'b0;
    d.byte_last = 1'b0;
    d.not_ready = ~I_STARTUP_DONE; // see R1

    // Faults seen at any point in the cycle stick until its end.
    d.rail_acc = q.rail_acc | rail_now; // see R6
    d.ref_acc = q.ref_acc | ref_now; // see R10

    // Host clears the power-on flag by writing zero; a new event wins.
    if (I_STATUS_WR && !I_STATUS_WDATA[fault_crc_pkg::STAT_POWER_ON_BIT])
    begin
      d.power_on_event_flag = 1'b0; // see R17
    end
    if (I_POWER_ON_EVENT)
    begin
      d.power_on_event_flag = 1'b1; // see R17
    end

    // End of conversion: publish the cycle's faults, including this cycle's
    // sample, restart accumulation and drop the done output.
    if (I_CONV_END)
    begin
      d.pos_out_high_flag = d.rail_acc[fault_crc_pkg::RAIL_POS_HIGH]; // see R6
      d.pos_out_low_flag = d.rail_acc[fault_crc_pkg::RAIL_POS_LOW];
      d.neg_out_high_flag = d.rail_acc[fault_crc_pkg::RAIL_NEG_HIGH];
      d.neg_out_low_flag = d.rail_acc[fault_crc_pkg::RAIL_NEG_LOW];
      d.ref_below_third_flag = d.ref_acc[1]; // see R10
      d.ref_below_fixed_flag = d.ref_acc[0];
      d.rail_acc = 4'h0;
      d.ref_acc = 2'h0;
      d.result = I_RESULT;
      d.conversion_done_out_n = 1'b0; // see R10
    end

    case (q.st)
      fault_crc_pkg::ST_IDLE:
      begin
        d.st = fault_crc_pkg::ST_IDLE;
      end
      fault_crc_pkg::ST_SEND:
      begin
        if (I_BYTE_REQ)
        begin
          d.byte_out = q.frame[q.idx];
          d.byte_valid = 1'b1;
          d.idx = q.idx + 2'h1;
          if (q.idx == q.last)
          begin
            d.byte_last = 1'b1;
            d.st = fault_crc_pkg::ST_IDLE;
          end
        end
      end
      default:
      begin
        d.st = fault_crc_pkg::ST_IDLE;
      end
    endcase

    // A read start snapshots the frame; it also restarts a read in progress.
    // The frame reflects the state before any conversion end in this cycle.
    if (I_READ_START)
    begin
      d.st = fault_crc_pkg::ST_SEND;
      d.frame[fault_crc_pkg::SLOT_STATUS] = status_now; // see R16
      d.frame[fault_crc_pkg::SLOT_RES_HI] = q.result[15:8];
      d.frame[fault_crc_pkg::SLOT_RES_LO] = q.result[7:0];
      d.frame[fault_crc_pkg::SLOT_CRC] = crc_chain[fault_crc_pkg::CRC_COVER_BYTES];
      d.idx = I_STATUS_PREPEND_BIT ?
        fault_crc_pkg::SLOT_STATUS : fault_crc_pkg::SLOT_RES_HI; // see R16
      d.last = I_CRC_EN ?
        fault_crc_pkg::SLOT_CRC : fault_crc_pkg::SLOT_RES_LO; // see R11
      if (!I_CONV_END)
      begin
        d.conversion_done_out_n = 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------------------

  // Reset is treated as a power-on event, so the flag comes up set.
  always_ff @(posedge I_CLK)
  begin
    if (I_SYS_RST)
    begin
      q <= '0;
      q.st <= fault_crc_pkg::ST_IDLE;
      q.power_on_event_flag <= fault_crc_pkg::RST_POWER_ON_FLAG; // see R17
      q.not_ready <= 1'b1; // see R1
      q.conversion_done_out_n <= fault_crc_pkg::RST_DONE_N;
    end
    else
    begin
      q <= d;
    end
  end

  // Outputs come straight from the state register.
  assign O_STATUS = {q.power_on_event_flag, q.not_ready, q.pos_out_high_flag,
    q.pos_out_low_flag, q.neg_out_high_flag, q.neg_out_low_flag,
    q.ref_below_third_flag, q.ref_below_fixed_flag};
  assign O_CONVERSION_DONE_OUT_N = q.conversion_done_out_n;
  assign O_BYTE = q.byte_out;
  assign O_BYTE_VALID = q.byte_valid;
  assign O_BYTE_LAST = q.byte_last;

endmodule : fault_status_crc

`default_nettype wire

// File: tb/fault_status_crc_assertions.sv
`timescale 1ns/1ps
`default_nettype none
// ----
// Port checks
// ----
module fault_status_crc_assertions
(
  input wire logic I_CLK,
  input wire logic I_SYS_RST,
  input wire logic [3:0] I_AMP_RAIL,
  input wire logic [3:0] I_ADC_IN_RAIL,
  input wire logic I_AMP_BYPASS,
  input wire logic I_RAIL_MON_EN,
  input wire logic I_REF_BELOW_FIXED,
  input wire logic I_REF_BELOW_THIRD,
  input wire logic [1:0] I_MONITOR_ENABLE_FIELD,
  input wire logic I_STARTUP_DONE,
  input wire logic I_POWER_ON_EVENT,
  input wire logic I_CONV_END,
  input wire logic I_STATUS_PREPEND_BIT,
  input wire logic I_STATUS_WR,
  input wire logic [7:0] I_STATUS_WDATA,
  input wire logic I_READ_START,
  input wire logic I_BYTE_REQ,
  input wire logic [7:0] O_STATUS,
  input wire logic O_CONVERSION_DONE_OUT_N,
  input wire logic [7:0] O_BYTE,
  input wire logic O_BYTE_VALID
);
  default clocking @(posedge I_CLK); endclocking
  default disable iff (I_SYS_RST);
  // Two ends in a row leave only one cycle of inputs in the latch.
  sequence two_ends;
    I_CONV_END && $past(I_CONV_END);
  endsequence
  chk_done_falls:
    assert property (I_CONV_END |=> !O_CONVERSION_DONE_OUT_N) else $error("ready stuck");
  chk_done_rises:
    assert property (I_READ_START && !I_CONV_END |=> O_CONVERSION_DONE_OUT_N)
    else $error("ready not released");
  chk_flags_hold:
    assert property (!I_CONV_END |=> $stable(O_STATUS[5:0])) else $error("flags moved");
  chk_rail_latch:
    assert property (two_ends |=> O_STATUS[5:2] == (!$past(I_RAIL_MON_EN) ? 4'h0
      : $past(I_AMP_BYPASS) ? $past(I_ADC_IN_RAIL) : $past(I_AMP_RAIL)))
    else $error("rail flags wrong");
  chk_ref_flags:
    assert property (two_ends |=> O_STATUS[1:0] == ($past(I_MONITOR_ENABLE_FIELD) == 2'h0
      ? 2'h0 : {$past(I_REF_BELOW_THIRD), $past(I_REF_BELOW_FIXED)}))
    else $error("ref flags wrong");
  chk_power_set:
    assert property (I_POWER_ON_EVENT |=> O_STATUS[7]) else $error("power flag not set");
  chk_power_clear:
    assert property (I_STATUS_WR && !I_STATUS_WDATA[7] && !I_POWER_ON_EVENT |=> !O_STATUS[7])
    else $error("power flag not cleared");
  chk_ready_bit:
    assert property (!$past(I_SYS_RST) |-> O_STATUS[6] == !$past(I_STARTUP_DONE))
    else $error("ready bit wrong");
  chk_status_first:
    assert property (I_READ_START && I_STATUS_PREPEND_BIT && !I_CONV_END ##1 I_BYTE_REQ
      |=> O_BYTE_VALID && O_BYTE == $past(O_STATUS, 2)) else $error("status not first");
  cover property (two_ends);
  cover property (O_BYTE_VALID ##1 O_BYTE_VALID);
  cover property (I_STATUS_WR && !I_STATUS_WDATA[7]);
endmodule : fault_status_crc_assertions
bind fault_status_crc fault_status_crc_assertions chk_u (.*);
`default_nettype wire

// File: tb/host_reader_model.sv
`timescale 1ns/1ps
`default_nettype none
// ----
// Host reader
// ----
module host_reader_model
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_go,
  input wire logic i_slow,
  input wire logic [2:0] i_count,
  input wire logic [7:0] i_byte,
  input wire logic i_valid,
  input wire logic i_last,
  output var logic o_read_start = 1'b0,
  output var logic o_byte_req = 1'b0,
  output var logic [31:0] o_frame = 32'h0,
  output var logic [7:0] o_crc_prev = 8'h00,
  output logic o_idle
);
  logic busy_q = 1'b0;
  logic pend_q = 1'b0;
  logic [2:0] left_q = 3'h0;
  logic [7:0] crc_q = 8'h00;
  // Bitwise division by 107h, which equals the long division with 8 zeros appended.
  function automatic logic [7:0] crc_step(input logic [7:0] c, input logic [7:0] d);
    logic [7:0] r;
    r = c ^ d;
    for (int i = 0; i < 8; i++)
      r = r[7] ? ({r[6:0], 1'b0} ^ 8'h07) : {r[6:0], 1'b0};
    return r;
  endfunction : crc_step
  assign o_idle = !busy_q;
  // Slow mode waits for each byte before asking again; fast mode asks every cycle.
  always @(posedge i_clk)
  begin
    o_read_start <= 1'b0;
    o_byte_req <= 1'b0;
    if (i_rst)
    begin
      busy_q <= 1'b0;
      left_q <= 3'h0;
    end
    else if (i_go)
    begin
      o_read_start <= 1'b1;
      busy_q <= 1'b1;
      pend_q <= 1'b0;
      left_q <= i_count;
      o_frame <= 32'h0;
      crc_q <= 8'h00;
    end
    else
    begin
      if (busy_q && i_valid)
      begin
        o_frame <= {o_frame[23:0], i_byte};
        o_crc_prev <= crc_q;
        crc_q <= crc_step(crc_q, i_byte);
        pend_q <= 1'b0;
        busy_q <= !i_last;
      end
      if (left_q != 3'h0 && (!i_slow || !pend_q))
      begin
        o_byte_req <= 1'b1;
        pend_q <= 1'b1;
        left_q <= left_q - 3'h1;
      end
    end
  end
endmodule : host_reader_model
`default_nettype wire

// File: tb/fault_status_crc_bench.sv
`timescale 1ns/1ps
`default_nettype none
// ----
// Bench
// ----
module fault_status_crc_bench;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] amp = 4'h0;
  logic [3:0] adc = 4'h0;
  logic [1:0] fld = 2'h0;
  logic byp, men, rfx, rth, sup, pev, cend, crc, pre, wr, go, slow;
  logic [2:0] cnt = 3'h0;
  logic [15:0] res = 16'h0080;
  logic rds, req, dn, val, lst, idle;
  logic [7:0] st, rx, cprev;
  logic [31:0] frame;
  logic [23:0] exp;
  int error_cnt = 0;
  int checked = 0;
  fault_status_crc dut_u
  (
    .I_CLK(clk), .I_SYS_RST(rst), .I_AMP_RAIL(amp), .I_ADC_IN_RAIL(adc), .I_AMP_BYPASS(byp),
    .I_RAIL_MON_EN(men), .I_REF_BELOW_FIXED(rfx), .I_REF_BELOW_THIRD(rth),
    .I_MONITOR_ENABLE_FIELD(fld), .I_STARTUP_DONE(sup), .I_POWER_ON_EVENT(pev),
    .I_CONV_END(cend), .I_RESULT(res), .I_CRC_EN(crc), .I_STATUS_PREPEND_BIT(pre),
    .I_STATUS_WR(wr), .I_STATUS_WDATA(8'h7f), .I_READ_START(rds), .I_BYTE_REQ(req),
    .O_STATUS(st), .O_CONVERSION_DONE_OUT_N(dn), .O_BYTE(rx), .O_BYTE_VALID(val),
    .O_BYTE_LAST(lst)
  );
  host_reader_model host_u
  (
    .i_clk(clk), .i_rst(rst), .i_go(go), .i_slow(slow), .i_count(cnt), .i_byte(rx),
    .i_valid(val), .i_last(lst), .o_read_start(rds), .o_byte_req(req), .o_frame(frame),
    .o_crc_prev(cprev), .o_idle(idle)
  );
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] want);
    checked++;
    if (seen !== want)
    begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", name, want, seen);
    end
  endtask : check
  task automatic close_out();
    if (error_cnt == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : close_out
  // A conversion end held n cycles; returns once the flags have landed.
  task automatic conv(input int n);
    @(posedge clk) cend <= 1'b1;
    repeat (n) @(posedge clk);
    cend <= 1'b0;
    @(negedge clk);
  endtask : conv
  // Clock at 25 MHz.
  always #20 clk = ~clk;
  // Watchdog: the sequence needs well under a thousand cycles.
  initial
  begin
    repeat (5000) @(posedge clk);
    error_cnt++;
    close_out();
  end
  // Main sequence.
  initial
  begin
    {byp, men, rfx, rth, sup, pev, cend, crc, pre, wr, go, slow} = '0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk) check("status", st, 8'hc0);
    check("ready", dn, 1'b1);
    @(posedge clk) sup <= 1'b1;
    repeat (2) @(negedge clk);
    check("bit6", st[6], 1'b0);
    @(posedge clk) wr <= 1'b1;
    @(posedge clk) wr <= 1'b0;
    pev <= 1'b1;
    @(negedge clk) check("por_clr", st[7], 1'b0);
    @(posedge clk) pev <= 1'b0;
    @(negedge clk) check("por_set", st[7], 1'b1);
    // A clear and a new event in one cycle: the event must win.
    @(posedge clk) wr <= 1'b1;
    pev <= 1'b1;
    @(posedge clk) wr <= 1'b0;
    pev <= 1'b0;
    @(negedge clk) check("por_win", st[7], 1'b1);
    for (int i = 0; i < 4; i++)
    begin
      @(posedge clk) amp <= 4'h1 << i;
      men <= 1'b1;
      @(posedge clk) amp <= 4'h0;
      @(negedge clk) check("rail_wait", st[5:2], 4'h0);
      conv(1);
      check("rail", st[5:2], 4'h1 << i);
      check("ready", dn, 1'b0);
      conv(1);
      check("rail_clr", st[5:2], 4'h0);
    end
    for (int i = 0; i < 3; i++)
    begin
      @(posedge clk) amp <= 4'hf;
      adc <= 4'h5;
      men <= (i != 0);
      byp <= (i == 1);
      conv(2);
      check("rail_mode", st[5:2], i == 0 ? 4'h0 : i == 1 ? 4'h5 : 4'hf);
    end
    for (int f = 0; f < 4; f++)
    begin
      @(posedge clk) fld <= f[1:0];
      rfx <= 1'b1;
      rth <= (f != 3);
      conv(2);
      check("ref", st[1:0], f == 0 ? 2'h0 : f == 3 ? 2'h1 : 2'h3);
    end
    for (int m = 0; m < 4; m++)
    begin
      // A second result value makes the byte order and the capture visible.
      @(posedge clk) res <= m[1] ? 16'h5a3c : 16'h0080;
      conv(1);
      // Latched status by now: power-on, all four rails, reference below fixed.
      exp = {m[1] ? 8'hbd : 8'h00, res};
      @(posedge clk) go <= 1'b1;
      pre <= m[1];
      crc <= m[0];
      slow <= m[0] ^ m[1];
      cnt <= 3'(2 + m[1] + m[0]);
      @(posedge clk) go <= 1'b0;
      @(negedge clk);
      for (int k = 0; k < 40 && !idle; k++) @(negedge clk);
      check("last", idle, 1'b1);
      check("frame", m[0] ? frame[31:8] : frame[23:0], exp);
      if (m[0])
        check("crc", frame[7:0], m[1] ? cprev : 8'h89);
      check("ready", dn, 1'b1);
    end
    close_out();
  end
endmodule : fault_status_crc_bench
`default_nettype wire
